//--- bench/transfer_ctrl_bus_activation_bench.sv
module transfer_ctrl_bus_activation_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, srst, act_irq, act_periph, nmi, err_clr, load, slow;
  logic [2:0]  release_sel;
  logic [7:0]  chains;
  wire         bus_grant, bus_cyc_ack, bus_req, bus_cyc_valid, busy;
  wire         err_flag, cfg_err;
  wire  [2:0]  bus_cyc_kind;
  wire  [31:0] bus_rdata, bus_wdata;
  wire  [7:0]  xfer_count;
  int          fail_count, n_tests, i;
  transfer_ctrl_bus_activation transfer_ctrl_bus_activation_inst (.sys_clk,
    .srst, .act_irq, .act_periph, .nmi, .release_sel, .bus_grant,
    .bus_cyc_ack, .bus_rdata, .err_clr, .bus_req, .bus_cyc_valid,
    .bus_cyc_kind, .bus_wdata, .busy, .err_flag, .cfg_err, .xfer_count);
  xfer_bus_model xfer_bus_model_inst (.sys_clk, .srst, .bus_req,
    .bus_cyc_valid, .bus_cyc_kind, .chains, .load, .slow, .bus_grant,
    .bus_cyc_ack, .bus_rdata);
  // ==========================================================
  // Checks and verdict
  function automatic logic exp_cfg(input int s);
    exp_cfg = s < 1 || s > 5;
  endfunction
  task automatic compare(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // One activation; requests repeated while busy must be ignored
  task automatic run_act(input int irq, sel, nch, slo);
    int k;
    int rises;
    logic pb;
    logic [7:0] xc;
    logic [31:0] rd;
    release_sel <= 3'(sel);
    chains <= 8'(nch);
    load <= 1'b1;
    slow <= slo != 0;
    @(posedge sys_clk);
    load <= 1'b0;
    act_irq <= irq != 0;
    act_periph <= irq == 0 | $urandom_range(1) == 1;
    rises = 0;
    pb = 0;
    xc = 0;
    for (k = 0; k < 3000; k++) begin
      @(posedge sys_clk);
      if (k == 12) begin
        act_irq <= 1'b0;
        act_periph <= 1'b0;
      end
      if (busy && !pb) rises++;
      pb = busy;
      if (bus_cyc_ack && bus_cyc_kind == 3'h6) xc = xfer_count;
      if (bus_cyc_ack && bus_cyc_kind == 3'h5)
        compare("bus_wdata", rd, bus_wdata);
      if (bus_cyc_ack && bus_cyc_kind == 3'h4) rd = bus_rdata;
      if (k > 12 && !busy) break;
    end
    repeat (4) @(posedge sys_clk);
    compare("activations", 1, rises);
    compare("busy", 0, busy);
    compare("transfers", 32'(nch + 1), xc);
    compare("cfg_err", exp_cfg(sel), cfg_err);
    compare("err_flag", 0, err_flag);
    $display("test act src %0d sel %0d chains %0d done", irq, sel, nch);
  endtask
  task automatic nmi_test(input int irq);
    nmi <= 1'b1;
    act_irq <= irq != 0;
    act_periph <= irq == 0;
    @(posedge sys_clk);
    act_irq <= 1'b0;
    act_periph <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nmi <= 1'b0;
    repeat (20) @(posedge sys_clk);
    compare("err_flag", 1, err_flag);
    compare("bus_req", 0, bus_req);
    err_clr <= 1'b1;
    @(posedge sys_clk);
    err_clr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    compare("err_flag", 0, err_flag);
    $display("test nmi src %0d done", irq);
  endtask
  // ==========================================================
  // Clock, watchdog, sequence
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    summarize;
  end
  initial begin
    {srst, act_irq, act_periph, nmi, err_clr, load, slow} = 7'h41;
    release_sel = 3'h5;
    chains = 8'h00;
    void'($urandom(32'he6f4_1e91));
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    for (i = 1; i <= 5; i++) run_act(i % 2, i, i % 3, i / 3);
    run_act(1, 0, 1, 1);
    run_act(0, 7, 2, 0);
    nmi_test(1);
    nmi_test(0);
    for (i = 0; i < 14; i++) begin
      run_act($urandom_range(1), $urandom_range(5, 1), $urandom_range(3),
        $urandom_range(1));
    end
    summarize;
  end
endmodule // transfer_ctrl_bus_activation_bench
bind transfer_ctrl_bus_activation xfer_act_chk xfer_act_chk_inst (.sys_clk,
  .srst, .act_irq, .act_periph, .nmi, .release_sel, .bus_grant, .bus_cyc_ack,
  .bus_rdata, .bus_req, .bus_cyc_valid, .bus_cyc_kind, .busy, .err_flag);

//--- bench/xfer_act_chk.sv
module xfer_act_chk (
  input wire        sys_clk,
  input wire        srst,
  input wire        act_irq,
  input wire        act_periph,
  input wire        nmi,
  input wire [2:0]  release_sel,
  input wire        bus_grant,
  input wire        bus_cyc_ack,
  input wire [31:0] bus_rdata,
  input wire        bus_req,
  input wire        bus_cyc_valid,
  input wire [2:0]  bus_cyc_kind,
  input wire        busy,
  input wire        err_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [2:0] last_kind;
  reg  [7:0] wr_n;
  reg  [7:0] ch_n;
  reg        more;
  wire [2:0] rel_kind = (release_sel == 3'h4) ? 3'h5 :
    (release_sel >= 3'h1 && release_sel <= 3'h3) ? release_sel : 3'h6;
  // ==========================================================
  // Bus cycle bookkeeping
  always @(posedge sys_clk) begin
    if (srst || !busy) begin
      wr_n <= 8'h00;
      ch_n <= 8'h00;
    end else if (bus_cyc_ack && bus_cyc_kind == 3'h5) begin
      wr_n <= wr_n + 8'h01;
    end else if (bus_cyc_ack && bus_cyc_kind == 3'h3) begin
      ch_n <= ch_n + {7'h00, bus_rdata[31]};
    end
    if (bus_cyc_ack && bus_cyc_kind == 3'h3) begin
      more <= bus_rdata[31];
    end
    last_kind <= srst ? 3'h0 : bus_cyc_ack ? bus_cyc_kind : last_kind;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_cyc_owns_bus: assert property ($rose(bus_cyc_valid) |->
    bus_req && $past(bus_grant)) else $error("cycle without bus");
  a_cyc_holds_bus: assert property (bus_cyc_valid && !bus_cyc_ack |=>
    bus_cyc_valid && bus_req && $stable(bus_cyc_kind))
    else $error("bus dropped mid cycle");
  a_req_waits: assert property (bus_req && !bus_grant |=> bus_req)
    else $error("request withdrawn before grant");
  a_rel_point: assert property ($fell(bus_req) |->
    ($past(bus_cyc_ack) || $past(bus_cyc_ack, 2)) &&
    last_kind inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6})
    else $error("bus released at bad point");
  a_rel_setting: assert property ($fell(bus_req) && busy |->
    last_kind == rel_kind) else $error("release point wrong");
  a_nmi_wins: assert property (nmi && !busy && !err_flag &&
    (act_irq || act_periph) |-> (!err_flag && !bus_req)[*6] ##[6:10]
    err_flag) else $error("nmi conflict mishandled");
  a_irq_recog: assert property ($rose(busy) && $past(act_irq) &&
    !$past(nmi) |-> !bus_req[*2] ##[2:3] bus_req)
    else $error("pin recognition time");
  a_per_recog: assert property ($rose(busy) && !$past(act_irq) &&
    $past(act_periph) && !$past(nmi) |-> !bus_req ##[1:4] bus_req)
    else $error("peripheral recognition time");
  a_ends_wb: assert property ($fell(busy) && !err_flag |->
    last_kind == 3'h6) else $error("ended without writeback");
  a_chain_count: assert property (bus_cyc_ack && bus_cyc_kind == 3'h6 &&
    !more |-> wr_n == ch_n + 8'h01) else $error("transfer count");
endmodule // xfer_act_chk

//--- bench/xfer_bus_model.sv
module xfer_bus_model (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        bus_req,
  input  wire        bus_cyc_valid,
  input  wire [2:0]  bus_cyc_kind,
  input  wire [7:0]  chains,
  input  wire        load,
  input  wire        slow,
  output reg         bus_grant,
  output reg         bus_cyc_ack,
  output reg  [31:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] left;
  reg       fin;
  // ==========================================================
  // Arbiter and bus, prompt or slow
  always @(posedge sys_clk) begin
    fin = bus_cyc_valid && !bus_cyc_ack && (!slow || $urandom_range(2) == 0);
    bus_grant <= bus_req && (bus_grant || !slow || $urandom_range(3) == 0);
    bus_cyc_ack <= fin;
    bus_rdata <= ~bus_rdata;
    if (load) begin
      left <= chains;
    end
    if (fin) begin
      bus_rdata <= {left != 8'h00, 31'($urandom)};
      if (bus_cyc_kind == 3'h3 && left != 8'h00) begin
        left <= left - 8'h01;
      end
    end
    if (srst) begin
      bus_grant <= 1'b0;
      bus_cyc_ack <= 1'b0;
      bus_rdata <= 32'h5a5a_5a5a;
    end
  end
endmodule // xfer_bus_model

//--- core/transfer_ctrl_bus_activation.v
`include "xfer_ctrl_map.vh"

// ============================================================
// Data FIFO
module xfer_fifo #(
  parameter W  = 32,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire         sys_clk,
  input  wire         srst,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;
  wire         push = in_valid && in_ready;
  wire         pop  = out_valid && out_ready;

  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // xfer_fifo

// ============================================================
// Activation and bus ownership control
module transfer_ctrl_bus_activation (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        act_irq,
  input  wire        act_periph,
  input  wire        nmi,
  input  wire [2:0]  release_sel,
  input  wire        bus_grant,
  input  wire        bus_cyc_ack,
  input  wire [31:0] bus_rdata,
  input  wire        err_clr,
  output reg         bus_req,
  output reg         bus_cyc_valid,
  output reg  [2:0]  bus_cyc_kind,
  output reg  [31:0] bus_wdata,
  output reg         busy,
  output reg         err_flag,
  output reg         cfg_err,
  output reg  [7:0]  xfer_count
);
  localparam [10:0] S_IDLE  = 11'h001;
  localparam [10:0] S_RECOG = 11'h002;
  localparam [10:0] S_GRANT = 11'h004;
  localparam [10:0] S_VEC   = 11'h008;
  localparam [10:0] S_NOP   = 11'h010;
  localparam [10:0] S_INFO  = 11'h020;
  localparam [10:0] S_RD    = 11'h040;
  localparam [10:0] S_WR    = 11'h080;
  localparam [10:0] S_WB    = 11'h100;
  localparam [10:0] S_STOP  = 11'h200;
  localparam [10:0] S_DONE  = 11'h400;
  reg [10:0] state;
  reg [10:0] resume;
  reg [3:0]  b_div;
  reg [3:0]  p_div;
  reg        b_en;
  reg        p_en;
  reg [1:0]  cnt;
  reg        nmi_ph;
  reg        src_irq;
  reg [2:0]  rel;
  reg        chain;
  wire [31:0] fifo_out;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        push = (state == S_RD) && bus_cyc_valid && bus_cyc_ack &&
                     fifo_in_ready;
  wire        pop  = (state == S_WR) && !bus_cyc_valid && fifo_out_valid;
  function [2:0] kind_of;
    input [10:0] st;
    begin
      case (st)
        S_VEC:   kind_of = `XC_KIND_VEC;
        S_NOP:   kind_of = `XC_KIND_NOP;
        S_INFO:  kind_of = `XC_KIND_INFO;
        S_RD:    kind_of = `XC_KIND_RD;
        S_WR:    kind_of = `XC_KIND_WR;
        S_WB:    kind_of = `XC_KIND_WB;
        default: kind_of = `XC_KIND_NONE;
      endcase
    end
  endfunction
  xfer_fifo #(
    .W  (`XC_DATA_W),
    .D  (`XC_FIFO_DEPTH),
    .AW (`XC_FIFO_AW)
  ) xfer_fifo_inst (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_data   (bus_rdata),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (pop)
  );

  // ==========================================================
  // Bus and peripheral cycle enables
  always @(posedge sys_clk) begin
    if (srst) begin
      b_div <= 4'h0;
      p_div <= 4'h0;
      b_en  <= 1'b0;
      p_en  <= 1'b0;
    end else begin
      b_en  <= (b_div == `XC_B_DIV - 4'h1);
      p_en  <= (p_div == `XC_P_DIV - 4'h1);
      b_div <= (b_div == `XC_B_DIV - 4'h1) ? 4'h0 : b_div + 4'h1;
      p_div <= (p_div == `XC_P_DIV - 4'h1) ? 4'h0 : p_div + 4'h1;
    end
  end

  // ==========================================================
  // Sequencer
  task advance;
    input [10:0] target;
    input        release_here;
    begin
      bus_cyc_valid <= 1'b0;
      bus_cyc_kind  <= `XC_KIND_NONE;
      if (release_here) begin
        bus_req <= 1'b0;
        resume  <= target;
        state   <= S_GRANT;
      end else begin
        state   <= target;
      end
    end
  endtask

  always @(posedge sys_clk) begin
    if (srst) begin
      state         <= S_IDLE;
      resume        <= S_VEC;
      cnt           <= 2'h0;
      nmi_ph        <= 1'b0;
      src_irq       <= 1'b0;
      rel           <= `XC_REL_WB;
      chain         <= 1'b0;
      bus_req       <= 1'b0;
      bus_cyc_valid <= 1'b0;
      bus_cyc_kind  <= `XC_KIND_NONE;
      bus_wdata     <= 32'h0000_0000;
      busy          <= 1'b0;
      err_flag      <= 1'b0;
      cfg_err       <= 1'b0;
      xfer_count    <= 8'h00;
    end else begin
      if (err_clr) begin
        err_flag <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          cnt    <= 2'h0;
          nmi_ph <= 1'b0;
          if (nmi) begin
            busy  <= 1'b1;
            state <= S_STOP;
          end else if (act_irq || act_periph) begin
            busy       <= 1'b1;
            src_irq    <= act_irq;
            xfer_count <= 8'h00;
            state      <= S_RECOG;
            if (release_sel >= `XC_REL_VEC && release_sel <= `XC_REL_WB) begin
              rel     <= release_sel;
              cfg_err <= 1'b0;
            end else begin
              rel     <= `XC_REL_WB;
              cfg_err <= 1'b1;
            end
          end
        end
        S_RECOG: begin
          if (nmi) begin
            cnt   <= 2'h0;
            state <= S_STOP;
          end else if (src_irq ? b_en : p_en) begin
            if (cnt == (src_irq ? `XC_IRQ_BCYC : `XC_PER_PCYC) - 2'h1) begin
              bus_req <= 1'b1;
              resume  <= S_VEC;
              state   <= S_GRANT;
            end else begin
              cnt <= cnt + 2'h1;
            end
          end
        end
        S_GRANT: begin
          bus_req <= 1'b1;
          if (bus_req && bus_grant) begin
            state <= resume;
          end
        end
        S_STOP: begin
          if (nmi_ph ? p_en : b_en) begin
            if (cnt != (nmi_ph ? `XC_NMI_PCYC : `XC_NMI_BCYC) - 2'h1) begin
              cnt <= cnt + 2'h1;
            end else if (!nmi_ph) begin
              cnt    <= 2'h0;
              nmi_ph <= 1'b1;
            end else begin
              err_flag <= 1'b1;
              busy     <= 1'b0;
              state    <= S_IDLE;
            end
          end
        end
        S_DONE: begin
          bus_req <= 1'b0;
          busy    <= 1'b0;
          state   <= S_IDLE;
        end
        default: begin
          if (!bus_cyc_valid) begin
            if ((state != S_RD || fifo_in_ready) &&
                (state != S_WR || fifo_out_valid)) begin
              bus_cyc_valid <= 1'b1;
              bus_cyc_kind  <= kind_of(state);
              if (state == S_WR) begin
                bus_wdata <= fifo_out;
              end
            end
          end else if (bus_cyc_ack && (state != S_RD || fifo_in_ready)) begin
            case (state)
              S_VEC:  advance(S_NOP, rel == `XC_REL_VEC);
              S_NOP:  advance(S_INFO, rel == `XC_REL_NOP);
              S_INFO: begin
                chain <= bus_rdata[`XC_CHAIN_BIT];
                advance(S_RD, rel == `XC_REL_INFO);
              end
              S_RD:   advance(S_WR, 1'b0);
              S_WR: begin
                xfer_count <= xfer_count + 8'h01;
                advance(S_WB, rel == `XC_REL_DATA);
              end
              default: advance(chain ? S_INFO : S_DONE,
                               chain && rel == `XC_REL_WB);
            endcase
          end
        end
      endcase
    end
  end
endmodule // transfer_ctrl_bus_activation

//--- core/xfer_ctrl_map.vh
`ifndef XFER_CTRL_MAP_VH
`define XFER_CTRL_MAP_VH

// System clocks per external-bus and per peripheral clock cycle
`define XC_B_DIV      4'h2
`define XC_P_DIV      4'h4
// Recognition and stop-decision times, in bus or peripheral cycles
`define XC_IRQ_BCYC   2'h2
`define XC_PER_PCYC   2'h1
`define XC_NMI_BCYC   2'h1
`define XC_NMI_PCYC   2'h3
// Bus-release settings of bus_function_extend_reg
`define XC_REL_VEC    3'h1
`define XC_REL_NOP    3'h2
`define XC_REL_INFO   3'h3
`define XC_REL_DATA   3'h4
`define XC_REL_WB     3'h5
// Bus cycle kinds
`define XC_KIND_NONE  3'h0
`define XC_KIND_VEC   3'h1
`define XC_KIND_NOP   3'h2
`define XC_KIND_INFO  3'h3
`define XC_KIND_RD    3'h4
`define XC_KIND_WR    3'h5
`define XC_KIND_WB    3'h6
// Position of chain_enable_bit in the transfer-information word
`define XC_CHAIN_BIT  31
// Data path
`define XC_DATA_W     32
`define XC_FIFO_DEPTH 16
`define XC_FIFO_AW    4

`endif
